// ==== logic/gos_pkg.sv ====
// gos_pkg: register map, reset values and encodings of the gyro bias / self-test bank
package gos_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned AXES   = 3;

    // register offsets
    localparam logic [7:0] GYRO_X_SELFTEST_CODE_OFS  = 8'h00;
    localparam logic [7:0] GYRO_Y_SELFTEST_CODE_OFS  = 8'h01;
    localparam logic [7:0] GYRO_Z_SELFTEST_CODE_OFS  = 8'h02;
    localparam logic [7:0] ACCEL_X_SELFTEST_CODE_OFS = 8'h0D;
    localparam logic [7:0] ACCEL_Y_SELFTEST_CODE_OFS = 8'h0E;
    localparam logic [7:0] ACCEL_Z_SELFTEST_CODE_OFS = 8'h0F;
    localparam logic [7:0] GYRO_X_BIAS_HIGH_OFS      = 8'h13;
    localparam logic [7:0] GYRO_X_BIAS_LOW_OFS       = 8'h14;
    localparam logic [7:0] GYRO_Y_BIAS_HIGH_OFS      = 8'h15;
    localparam logic [7:0] GYRO_Y_BIAS_LOW_OFS       = 8'h16;
    localparam logic [7:0] GYRO_Z_BIAS_HIGH_OFS      = 8'h17;
    localparam logic [7:0] GYRO_Z_BIAS_LOW_OFS       = 8'h18;
    localparam logic [7:0] POWER_CTRL_OFS            = 8'h6B;

    // field positions
    localparam int unsigned POWER_SLEEP_BIT = 6;
    localparam int unsigned BIAS_HIGH_MSB   = 15;
    localparam int unsigned BIAS_HIGH_LSB   = 8;

    // reset values
    localparam logic [7:0] BIAS_RST        = 8'h00;
    localparam logic [7:0] POWER_CTRL_RST  = 8'h40;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // saturation limits of a 16-bit signed sample
    localparam logic signed [15:0] SAMPLE_MAX = 16'sh7FFF;
    localparam logic signed [15:0] SAMPLE_MIN = -16'sh8000;

    typedef enum logic [1:0] {
        GOS_PWR_SLEEP  = 2'b01,
        GOS_PWR_ACTIVE = 2'b10
    } gos_pwr_state_t;
endpackage

// ==== logic/gos_regs.sv ====
// gos_regs: self-test code registers, gyro user bias registers and bias adder
`timescale 1ns/10ps
`default_nettype none

// How it works
// - after reset the block sleeps until software clears the sleep bit.
// - three 8-bit gyro self-test code registers sit at offsets 00 to 02.
// - three 8-bit accel self-test code registers sit at offsets 0D to 0F.
// - bias high bytes hold bits 15..8 at offsets 13, 15 and 17.
// - bias low bytes hold bits 7..0 at offsets 14 and 16.
// - z-axis bias low byte sits at offset 18.
// - each assembled 16-bit bias is signed two's complement.
// - each gyro sample has its axis bias added before reaching the output.
// - bias registers reset to zero; self-test codes reload factory values.
module gos_regs
    import gos_pkg::*;
#(
    parameter logic [7:0] GYRO_X_FACTORY_CODE  = 8'h5A,
    parameter logic [7:0] GYRO_Y_FACTORY_CODE  = 8'h5B,
    parameter logic [7:0] GYRO_Z_FACTORY_CODE  = 8'h5C,
    parameter logic [7:0] ACCEL_X_FACTORY_CODE = 8'h4A,
    parameter logic [7:0] ACCEL_Y_FACTORY_CODE = 8'h4B,
    parameter logic [7:0] ACCEL_Z_FACTORY_CODE = 8'h4C,
    parameter int unsigned SAMPLE_W            = 16
)
(
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 sys_rst_i,
    // register port
    input  wire logic [ADDR_W-1:0]    reg_addr_i,
    input  wire logic [DATA_W-1:0]    reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [DATA_W-1:0]    reg_rdata_o,
    // raw gyro samples, one strobe for all three axes
    input  wire logic                 raw_valid_i,
    input  wire logic [SAMPLE_W-1:0]  raw_x_i,
    input  wire logic [SAMPLE_W-1:0]  raw_y_i,
    input  wire logic [SAMPLE_W-1:0]  raw_z_i,
    // corrected gyro outputs
    output logic                      gyro_valid_o,
    output logic      [SAMPLE_W-1:0]  gyro_x_o,
    output logic      [SAMPLE_W-1:0]  gyro_y_o,
    output logic      [SAMPLE_W-1:0]  gyro_z_o,
    // power state
    output logic                      sleep_o
);

    // the adder and its clamp limits are built for 16-bit samples only
    if (SAMPLE_W != 16)
    begin : g_bad_width
        $error("gos_regs: SAMPLE_W must be 16");
    end

    logic [7:0]           gyro_code_ff  [AXES];
    logic [7:0]           accel_code_ff [AXES];
    logic [7:0]           bias_high_ff  [AXES];
    logic [7:0]           bias_low_ff   [AXES];
    logic [7:0]           power_ctrl_ff;
    gos_pwr_state_t       pwr_state_ff;
    logic [DATA_W-1:0]    rdata_ff;
    logic                 gyro_valid_ff;
    logic [SAMPLE_W-1:0]  gyro_out_ff   [AXES];
    logic [SAMPLE_W-1:0]  raw_sample    [AXES];
    logic [SAMPLE_W-1:0]  nxt_gyro_out  [AXES];

    assign raw_sample[0] = raw_x_i;
    assign raw_sample[1] = raw_y_i;
    assign raw_sample[2] = raw_z_i;

    // widen by one bit, add, clamp back to 16 bits
    function automatic logic [15:0] sat_add(input logic [15:0] raw, input logic [15:0] bias);
        logic signed [16:0] sum;
        sum = 17'(signed'(raw)) + 17'(signed'(bias));
        if (sum > 17'(SAMPLE_MAX))
            sat_add = SAMPLE_MAX;
        else if (sum < 17'(SAMPLE_MIN))
            sat_add = SAMPLE_MIN;
        else
            sat_add = sum[15:0];
    endfunction

    function automatic logic [7:0] factory_code(input int unsigned kind, input int unsigned ax);
        logic [7:0] g [AXES];
        logic [7:0] a [AXES];
        g[0] = GYRO_X_FACTORY_CODE;
        g[1] = GYRO_Y_FACTORY_CODE;
        g[2] = GYRO_Z_FACTORY_CODE;
        a[0] = ACCEL_X_FACTORY_CODE;
        a[1] = ACCEL_Y_FACTORY_CODE;
        a[2] = ACCEL_Z_FACTORY_CODE;
        factory_code = (kind == 0) ? g[ax] : a[ax];
    endfunction

    // per-axis register storage and bias path
    for (genvar ax = 0; ax < AXES; ax++)
    begin : g_axis
        localparam logic [7:0] GCODE_OFS = GYRO_X_SELFTEST_CODE_OFS + 8'(ax);
        localparam logic [7:0] ACODE_OFS = ACCEL_X_SELFTEST_CODE_OFS + 8'(ax);
        localparam logic [7:0] HIGH_OFS  = GYRO_X_BIAS_HIGH_OFS + 8'(2 * ax);
        localparam logic [7:0] LOW_OFS   = GYRO_X_BIAS_LOW_OFS + 8'(2 * ax);

        // codes are writable but come back to factory values at reset
        always_ff @(posedge sys_clk_i)
        begin
            if (sys_rst_i)
            begin
                gyro_code_ff[ax]  <= factory_code(0, ax);
                accel_code_ff[ax] <= factory_code(1, ax);
            end
            else if (reg_wr_i)
            begin
                if (reg_addr_i == GCODE_OFS)
                    gyro_code_ff[ax] <= reg_wdata_i;
                if (reg_addr_i == ACODE_OFS)
                    accel_code_ff[ax] <= reg_wdata_i;
            end
        end

        always_ff @(posedge sys_clk_i)
        begin
            if (sys_rst_i)
            begin
                bias_high_ff[ax] <= BIAS_RST;
                bias_low_ff[ax]  <= BIAS_RST;
            end
            else if (reg_wr_i)
            begin
                if (reg_addr_i == HIGH_OFS)
                    bias_high_ff[ax] <= reg_wdata_i;
                if (reg_addr_i == LOW_OFS)
                    bias_low_ff[ax] <= reg_wdata_i;
            end
        end

        assign nxt_gyro_out[ax] = sat_add(raw_sample[ax],
                                          {bias_high_ff[ax], bias_low_ff[ax]});

        // a sleeping block does not sample
        always_ff @(posedge sys_clk_i)
        begin
            if (sys_rst_i)
                gyro_out_ff[ax] <= 16'h0000;
            else if (raw_valid_i && pwr_state_ff == GOS_PWR_ACTIVE)
                gyro_out_ff[ax] <= nxt_gyro_out[ax];
        end
    end

    // power configuration
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            power_ctrl_ff <= POWER_CTRL_RST;
        else if (reg_wr_i && reg_addr_i == POWER_CTRL_OFS)
            power_ctrl_ff <= reg_wdata_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            pwr_state_ff <= GOS_PWR_SLEEP;
        else
        begin
            case (pwr_state_ff)
                GOS_PWR_SLEEP:
                    if (!power_ctrl_ff[POWER_SLEEP_BIT])
                        pwr_state_ff <= GOS_PWR_ACTIVE;
                GOS_PWR_ACTIVE:
                    if (power_ctrl_ff[POWER_SLEEP_BIT])
                        pwr_state_ff <= GOS_PWR_SLEEP;
                default:
                    pwr_state_ff <= GOS_PWR_SLEEP;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            gyro_valid_ff <= 1'b0;
        else
            gyro_valid_ff <= raw_valid_i && pwr_state_ff == GOS_PWR_ACTIVE;
    end

    // read mux; unmapped offsets read zero
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            rdata_ff <= UNMAPPED_READ;
        else if (reg_rd_i)
        begin
            if (reg_addr_i == GYRO_X_SELFTEST_CODE_OFS)
                rdata_ff <= gyro_code_ff[0];
            else if (reg_addr_i == GYRO_Y_SELFTEST_CODE_OFS)
                rdata_ff <= gyro_code_ff[1];
            else if (reg_addr_i == GYRO_Z_SELFTEST_CODE_OFS)
                rdata_ff <= gyro_code_ff[2];
            else if (reg_addr_i == ACCEL_X_SELFTEST_CODE_OFS)
                rdata_ff <= accel_code_ff[0];
            else if (reg_addr_i == ACCEL_Y_SELFTEST_CODE_OFS)
                rdata_ff <= accel_code_ff[1];
            else if (reg_addr_i == ACCEL_Z_SELFTEST_CODE_OFS)
                rdata_ff <= accel_code_ff[2];
            else if (reg_addr_i == GYRO_X_BIAS_HIGH_OFS)
                rdata_ff <= bias_high_ff[0];
            else if (reg_addr_i == GYRO_X_BIAS_LOW_OFS)
                rdata_ff <= bias_low_ff[0];
            else if (reg_addr_i == GYRO_Y_BIAS_HIGH_OFS)
                rdata_ff <= bias_high_ff[1];
            else if (reg_addr_i == GYRO_Y_BIAS_LOW_OFS)
                rdata_ff <= bias_low_ff[1];
            else if (reg_addr_i == GYRO_Z_BIAS_HIGH_OFS)
                rdata_ff <= bias_high_ff[2];
            else if (reg_addr_i == GYRO_Z_BIAS_LOW_OFS)
                rdata_ff <= bias_low_ff[2];
            else if (reg_addr_i == POWER_CTRL_OFS)
                rdata_ff <= power_ctrl_ff;
            else
                rdata_ff <= UNMAPPED_READ;
        end
        else
            rdata_ff <= UNMAPPED_READ;
    end

    assign reg_rdata_o  = rdata_ff;
    assign gyro_valid_o = gyro_valid_ff;
    assign gyro_x_o     = gyro_out_ff[0];
    assign gyro_y_o     = gyro_out_ff[1];
    assign gyro_z_o     = gyro_out_ff[2];
    assign sleep_o      = (pwr_state_ff == GOS_PWR_SLEEP);

    // checks
    sequence s_wake;
        !power_ctrl_ff[POWER_SLEEP_BIT] && sleep_o;
    endsequence

    // write then read of the z accel code on back-to-back strobes
    sequence s_zcode_write;
        reg_wr_i && reg_addr_i == ACCEL_Z_SELFTEST_CODE_OFS;
    endsequence

    sequence s_zcode_read;
        reg_rd_i && reg_addr_i == ACCEL_Z_SELFTEST_CODE_OFS;
    endsequence

    sleep_after_reset_a: assert property (@(posedge sys_clk_i)
        $fell(sys_rst_i) |-> sleep_o)
        else $error("block not asleep after reset");

    sleep_no_sample_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        sleep_o |=> !gyro_valid_o)
        else $error("sample produced while asleep");

    wake_one_cycle_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s_wake |=> !sleep_o)
        else $error("wake did not follow clear of sleep bit");

    gcode_read_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == GYRO_Y_SELFTEST_CODE_OFS
            |=> reg_rdata_o == $past(gyro_code_ff[1]))
        else $error("gyro self-test code read mismatch");

    acode_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s_zcode_write ##1 s_zcode_read |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("accel self-test code not stored");

    bias_high_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == GYRO_Z_BIAS_HIGH_OFS |=> bias_high_ff[2] == $past(reg_wdata_i))
        else $error("z bias high byte not stored");

    bias_low_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == GYRO_Z_BIAS_LOW_OFS |=> bias_low_ff[2] == $past(reg_wdata_i))
        else $error("z bias low byte not stored");

    bias_reset_a: assert property (@(posedge sys_clk_i)
        $fell(sys_rst_i) |-> bias_high_ff[0] == BIAS_RST && bias_low_ff[1] == BIAS_RST
            && gyro_code_ff[0] == GYRO_X_FACTORY_CODE)
        else $error("reset values wrong");

    bias_add_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        raw_valid_i && !sleep_o |=> gyro_valid_o && gyro_x_o == $past(nxt_gyro_out[0]))
        else $error("bias sum not presented");

    saturate_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        raw_valid_i && !sleep_o && raw_y_i == 16'h7FFF && !bias_high_ff[1][7]
            |=> gyro_y_o == 16'h7FFF)
        else $error("positive overflow wrapped");

    saturate_neg_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        raw_valid_i && !sleep_o && raw_z_i == 16'h8000 && bias_high_ff[2][7]
            |=> gyro_z_o == 16'h8000)
        else $error("negative overflow wrapped");

    sleep_entry_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        power_ctrl_ff[POWER_SLEEP_BIT] && !sleep_o |=> sleep_o)
        else $error("sleep bit set but block stayed awake");

    // read data stand one cycle only; a late sampler sees zero
    rdata_idle_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !reg_rd_i |=> reg_rdata_o == UNMAPPED_READ)
        else $error("read data outlived their cycle");

    yhigh_read_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == GYRO_Y_BIAS_HIGH_OFS
            |=> reg_rdata_o == $past(bias_high_ff[1]))
        else $error("y bias high byte read mismatch");

    xlow_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == GYRO_X_BIAS_LOW_OFS |=> bias_low_ff[0] == $past(reg_wdata_i))
        else $error("x bias low byte not stored");

    ylow_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == GYRO_Y_BIAS_LOW_OFS |=> bias_low_ff[1] == $past(reg_wdata_i))
        else $error("y bias low byte not stored");

    power_read_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == POWER_CTRL_OFS |=> reg_rdata_o == $past(power_ctrl_ff))
        else $error("power control read mismatch");

    bias_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !reg_wr_i |=> $stable(bias_high_ff[0]) && $stable(bias_low_ff[2]))
        else $error("bias byte changed without a write");

    code_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !reg_wr_i |=> $stable(gyro_code_ff[0]) && $stable(accel_code_ff[2]))
        else $error("self-test code changed without a write");

    out_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !raw_valid_i || sleep_o |=> $stable(gyro_x_o) && $stable(gyro_z_o))
        else $error("gyro output changed without an accepted sample");

    valid_cause_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        gyro_valid_o |-> $past(raw_valid_i) && !$past(sleep_o))
        else $error("sample valid without an accepted raw sample");

    code_reload_a: assert property (@(posedge sys_clk_i)
        $fell(sys_rst_i) |-> accel_code_ff[2] == ACCEL_Z_FACTORY_CODE
            && bias_low_ff[2] == BIAS_RST)
        else $error("z code or z bias not reloaded");
endmodule

`default_nettype wire

// ==== dv/gos_host.sv ====
// host model: drives the register port of the bias and self-test bank
`timescale 1ns/10ps
`default_nettype none
module gos_host
    import gos_pkg::*;
(
    // clock
    input  wire logic              sys_clk_i,
    // register port
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic      [DATA_W-1:0] reg_wdata_o,
    output logic                   reg_wr_o,
    output logic                   reg_rd_o,
    input  wire logic [DATA_W-1:0] reg_rdata_i
);
    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o    <= 1'b0;
        // stale data would hide a missed strobe
        reg_wdata_o <= ~d;
    endtask

    // write then read of one offset with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= wd;
        reg_wr_o    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o    <= 1'b0;
        reg_wdata_o <= ~wd;
        reg_rd_o    <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o    <= 1'b0;
        @(negedge sys_clk_i);
        d = reg_rdata_i;
    endtask

    // data are taken in the single cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o   <= 1'b0;
        @(negedge sys_clk_i);
        d = reg_rdata_i;
    endtask

    // stored code to expected factory response in lsb
    function automatic real expected_factory_response(input int code, input int fs);
        return (2620.0 / (2.0 ** fs)) * (1.01 ** (code - 1));
    endfunction

    // factory response back to its stored code, rounded to nearest
    function automatic int stored_selftest_code(input real factory_measured_response,
                                                input int  full_scale_setting);
        return int'($ln(factory_measured_response / (2620.0 / (2.0 ** full_scale_setting)))
            / $ln(1.01)) + 1;
    endfunction

    // later self-test result judged against the stored code
    function automatic bit selftest_ok(input real measured, input int code, input int fs);
        real r;
        r = measured / expected_factory_response(code, fs);
        return (r > 0.5) && (r < 2.0);
    endfunction
endmodule
`default_nettype wire

// ==== dv/tb_gos_regs.sv ====
// self-checking bench of the gyro bias and self-test register bank
`timescale 1ns/10ps
`default_nettype none
module tb_gos_regs;
    import gos_pkg::*;
    localparam logic [47:0] FAC = 48'h21_32_43_54_65_76;
    localparam logic [95:0] OFS = 96'h00_01_02_0D_0E_0F_13_14_15_16_17_18;

    logic        sys_clk;
    logic        sys_rst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        raw_valid;
    logic [15:0] raw_x;
    logic [15:0] raw_y;
    logic [15:0] raw_z;
    logic        gyro_valid;
    logic [15:0] gx;
    logic [15:0] gy;
    logic [15:0] gz;
    logic        sleep;
    logic [7:0]  d;
    int          n_fail;
    int          n_checks;
    int          cyc;

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    gos_regs #(.GYRO_X_FACTORY_CODE(FAC[47:40]), .GYRO_Y_FACTORY_CODE(FAC[39:32]),
        .GYRO_Z_FACTORY_CODE(FAC[31:24]), .ACCEL_X_FACTORY_CODE(FAC[23:16]),
        .ACCEL_Y_FACTORY_CODE(FAC[15:8]), .ACCEL_Z_FACTORY_CODE(FAC[7:0]), .SAMPLE_W(16))
    DUT (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .raw_valid_i(raw_valid),
        .raw_x_i(raw_x), .raw_y_i(raw_y), .raw_z_i(raw_z), .gyro_valid_o(gyro_valid),
        .gyro_x_o(gx), .gyro_y_o(gy), .gyro_z_o(gz), .sleep_o(sleep));

    gos_host host (.sys_clk_i(sys_clk), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));

    task automatic final_report();
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] sat(input logic [15:0] b, input logic [15:0] r);
        int s;
        s = int'($signed(b)) + int'($signed(r));
        if (s > 32767)
            return 16'h7FFF;
        if (s < -32768)
            return 16'h8000;
        return s[15:0];
    endfunction

    task automatic do_reset();
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask

    task automatic send(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(posedge sys_clk);
        {raw_x, raw_y, raw_z} <= {x, y, z};
        raw_valid <= 1'b1;
        @(posedge sys_clk);
        raw_valid <= 1'b0;
        {raw_x, raw_y, raw_z} <= ~{x, y, z};
        @(negedge sys_clk);
    endtask

    // whole map after reset, then asleep samples are refused
    task automatic test_reset_map();
        for (int i = 0; i < 12; i++)
        begin
            host.rd(OFS[95-8*i -: 8], d);
            chk(16'(d), (i < 6) ? 16'(FAC[47-8*i -: 8]) : 16'h0000);
        end
        host.rd(8'h6B, d);
        chk(16'(d), 16'h0040);
        host.rd(8'h00, d);
        chk(16'(host.stored_selftest_code(host.expected_factory_response(int'(d), 0), 0)),
            16'(FAC[47:40]));
        chk(16'(host.selftest_ok(3600.0, int'(d), 0)), 16'h0001);
        chk(16'(host.selftest_ok(1000.0, int'(d), 0)), 16'h0000);
        send(16'h0100, 16'h0200, 16'h0300);
        chk(16'({sleep, gyro_valid}), 16'h0002);
    endtask

    // wake, all twelve code and bias registers written one after another then read, one unmapped place
    task automatic test_rw();
        host.wr(8'h6B, 8'h00);
        // sleep falls one edge after the control register takes the write
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(16'(sleep), 16'h0000);
        for (int i = 0; i < 12; i++)
            host.wr(OFS[95-8*i -: 8], 8'hC0 + 8'(i));
        host.wr(8'h03, 8'h55);
        for (int i = 0; i < 12; i++)
        begin
            host.rd(OFS[95-8*i -: 8], d);
            chk(16'(d), 16'hC0 + 16'(i));
        end
        host.wr_rd(8'h0F, 8'h3C, d);
        chk(16'(d), 16'h003C);
        host.rd(8'h03, d);
        chk(16'(d), 16'h0000);
        @(negedge sys_clk);
        chk(16'(rdata), 16'h0000);
    endtask

    // biases in place, then one sample with its sums checked and the z sum held
    task automatic test_sum(input logic [47:0] b, input logic [47:0] r);
        for (int i = 0; i < 6; i++)
            host.wr(OFS[47-8*i -: 8], b[47-8*i -: 8]);
        send(r[47:32], r[31:16], r[15:0]);
        chk(16'(gyro_valid), 16'h0001);
        chk(gx, sat(b[47:32], r[47:32]));
        chk(gy, sat(b[31:16], r[31:16]));
        chk(gz, sat(b[15:0], r[15:0]));
        @(negedge sys_clk);
        chk(16'(gyro_valid), 16'h0000);
        chk(gz, sat(b[15:0], r[15:0]));
    endtask

    // sleep entry refuses samples; a mid-run reset reloads codes, clears biases, sleeps
    task automatic test_reload();
        host.wr(8'h6B, 8'h40);
        send(16'h0001, 16'h0001, 16'h0001);
        chk(16'({sleep, gyro_valid}), 16'h0002);
        chk(gx, 16'h7FFF);
        host.wr(8'h6B, 8'h00);
        host.wr(8'h0E, 8'hEE);
        do_reset();
        host.rd(8'h0E, d);
        chk(16'(d), 16'(FAC[15:8]));
        host.rd(8'h17, d);
        chk(16'(d), 16'h0000);
        chk(16'(sleep), 16'h0001);
        chk(gx | gy | gz, 16'h0000);
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            final_report();
        end
    end

    initial
    begin
        {n_fail, n_checks, cyc} = '0;
        sys_rst = 1'b1;
        raw_valid = 1'b0;
        {raw_x, raw_y, raw_z} = '0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        test_reset_map();
        test_rw();
        test_sum(48'h0102_FFFB_7000, 48'h0064_0003_7000);
        test_sum(48'h8000_7FFF_FFFF, 48'h8000_8001_0001);
        test_sum(48'h0010_0005_8000, 48'h7FF0_7FFF_8000);
        test_reload();
        final_report();
    end
endmodule
`default_nettype wire
